// ==== include/matbl_pkg.sv ====
// Package: constants and types for the station address forwarding table
`default_nettype none
package matbl_pkg;
	localparam int ADDR_W      = 48;
	localparam int VLAN_W      = 12;
	localparam int PORT_W      = 5;
	localparam int NPORTS      = 18;
	localparam int DEPTH       = 16;
	localparam int IDX_W       = 4;
	localparam int FDEPTH      = 8;
	localparam int FIDX_W      = 3;
	localparam int AGE_W       = 10;
	localparam logic [AGE_W-1:0] AGE_DEF_S = 10'h12C;
	localparam logic [AGE_W-1:0] AGE_MIN_S = 10'h00A;
	localparam logic [AGE_W-1:0] AGE_MAX_S = 10'h276;
	localparam logic [VLAN_W-1:0] VLAN_MIN = 12'h001;
	localparam logic [VLAN_W-1:0] VLAN_MAX = 12'hFFE;
	localparam logic [PORT_W-1:0] CPU_PORT = 5'h12;
	localparam int CLK_HZ      = 40000000;
	localparam int TICK_CYC    = CLK_HZ;
	localparam int TICK_W      = 26;

	typedef enum logic [2:0] {
		MATBL_CMD_ADD_FIXED = 3'h0,
		MATBL_CMD_DEL_FIXED = 3'h1,
		MATBL_CMD_CONVERT   = 3'h2,
		MATBL_CMD_FLUSH     = 3'h3,
		MATBL_CMD_FLT_ADD   = 3'h4,
		MATBL_CMD_FLT_DEL   = 3'h5,
		MATBL_CMD_SET_AGE   = 3'h6,
		MATBL_CMD_READ_FROM = 3'h7
	} matbl_cmd_t;

	typedef struct packed {
		logic                  valid;
		logic                  fixed;
		logic [VLAN_W-1:0]     vlan;
		logic [ADDR_W-1:0]     addr;
		logic [NPORTS:0]       ports;
		logic [AGE_W-1:0]      age;
	} matbl_entry_t;
endpackage
`default_nettype wire

// ==== include/matbl_key_if.sv ====
// Interface: sorted key search request and answer
`timescale 1ns/1ps
`default_nettype none
interface matbl_key_if;
	import matbl_pkg::*;
	logic [VLAN_W-1:0] vlan;
	logic [ADDR_W-1:0] addr;
	logic              found;
	logic [IDX_W-1:0]  idx;
	modport req (output vlan, output addr, input found, input idx);
	modport srv (input vlan, input addr, output found, output idx);
endinterface
`default_nettype wire

// ==== rtl/matbl_next.sv ====
// Module: finds the smallest entry at or after a key in vlan-then-address order
`timescale 1ns/1ps
`default_nettype none
module matbl_next
	import matbl_pkg::*;
(
	input  wire matbl_entry_t tbl_in [DEPTH],
	input  wire logic         dyn_only_in,
	matbl_key_if.srv          key
);
	function automatic logic key_le(input logic [VLAN_W+ADDR_W-1:0] a,
		input logic [VLAN_W+ADDR_W-1:0] b);
		return a <= b;
	endfunction

	always_comb begin
		logic [VLAN_W+ADDR_W-1:0] best;
		logic [VLAN_W+ADDR_W-1:0] cur;
		best = '1;
		cur = '0;
		key.found = 1'b0;
		key.idx = '0;
		for (int i = 0; i < DEPTH; i++) begin
			cur = {tbl_in[i].vlan, tbl_in[i].addr};
			if (tbl_in[i].valid && !(dyn_only_in && tbl_in[i].fixed) &&
				key_le({key.vlan, key.addr}, cur) && (!key.found || !key_le(best, cur))) begin
				best = cur;
				key.found = 1'b1;
				key.idx = IDX_W'(i);
			end
		end
	end
endmodule
`default_nettype wire

// ==== rtl/matbl_top.sv ====
// Module: station address forwarding table with learning, aging and filtering
`timescale 1ns/1ps
`default_nettype none
module matbl_top
	import matbl_pkg::*;
(
	input  wire logic              sys_clk_in,
	input  wire logic              sys_rst_in,
	input  wire logic              frm_valid_in,
	input  wire logic [ADDR_W-1:0] destination_station_address_in,
	input  wire logic [ADDR_W-1:0] source_station_address_in,
	input  wire logic [VLAN_W-1:0] frm_vlan_in,
	input  wire logic [PORT_W-1:0] frm_port_in,
	output logic                   fwd_valid_out,
	output logic [NPORTS:0]        fwd_ports_out,
	output logic                   fwd_flood_out,
	output logic                   fwd_drop_out,
	input  wire logic              cmd_valid_in,
	input  wire logic [2:0]        cmd_op_in,
	input  wire logic [ADDR_W-1:0] cmd_addr_in,
	input  wire logic [VLAN_W-1:0] cmd_vlan_in,
	input  wire logic [PORT_W-1:0] cmd_port_in,
	input  wire logic [AGE_W-1:0]  cmd_age_in,
	input  wire logic              cmd_dyn_only_in,
	output logic                   cmd_done_out,
	output logic                   cmd_err_out,
	output logic                   rd_valid_out,
	output logic                   rd_found_out,
	output logic [ADDR_W-1:0]      rd_addr_out,
	output logic [VLAN_W-1:0]      rd_vlan_out,
	output logic [NPORTS:0]        rd_ports_out,
	output logic                   rd_fixed_out,
	output logic [AGE_W-1:0]       age_time_out
);
	// ------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------
	matbl_entry_t      tbl_ff [DEPTH];
	logic [FDEPTH-1:0] flt_v_ff;
	logic [ADDR_W-1:0] flt_a_ff [FDEPTH];
	logic [VLAN_W-1:0] flt_vl_ff [FDEPTH];
	logic [AGE_W-1:0]  age_time_ff;
	logic [TICK_W-1:0] tick_cnt_ff;
	logic              sec_tick;
	matbl_cmd_t        cmd_op;

	assign cmd_op = matbl_cmd_t'(cmd_op_in);
	assign sec_tick = (tick_cnt_ff == TICK_W'(TICK_CYC - 1));

	// Returns the slot that matches address and vlan, if any
	function automatic logic [IDX_W:0] find_slot(input logic [ADDR_W-1:0] a,
		input logic [VLAN_W-1:0] v, input matbl_entry_t t [DEPTH]);
		logic [IDX_W:0] r;
		r = '0;
		for (int i = 0; i < DEPTH; i++) begin
			if (t[i].valid && t[i].addr == a && t[i].vlan == v) begin
				r = {1'b1, IDX_W'(i)};
			end
		end
		return r;
	endfunction

	function automatic logic [FIDX_W:0] find_flt(input logic [ADDR_W-1:0] a,
		input logic [VLAN_W-1:0] v, input logic [FDEPTH-1:0] fv,
		input logic [ADDR_W-1:0] fa [FDEPTH], input logic [VLAN_W-1:0] fl [FDEPTH]);
		logic [FIDX_W:0] r;
		r = '0;
		for (int i = 0; i < FDEPTH; i++) begin
			if (fv[i] && fa[i] == a && fl[i] == v) begin
				r = {1'b1, FIDX_W'(i)};
			end
		end
		return r;
	endfunction

	function automatic logic [NPORTS:0] port_bit(input logic [PORT_W-1:0] p);
		logic [NPORTS:0] m;
		m = '0;
		m[p] = 1'b1;
		return m;
	endfunction

	// ------------------------------------------------------------
	// Free slot and key search
	// ------------------------------------------------------------
	logic             free_ok;
	logic [IDX_W-1:0] free_idx;
	always_comb begin
		free_ok = 1'b0;
		free_idx = '0;
		for (int i = DEPTH - 1; i >= 0; i--) begin
			if (!tbl_ff[i].valid) begin
				free_ok = 1'b1;
				free_idx = IDX_W'(i);
			end
		end
	end

	logic [FIDX_W-1:0] flt_free_idx;
	logic              flt_free_ok;
	always_comb begin
		flt_free_ok = 1'b0;
		flt_free_idx = '0;
		for (int i = FDEPTH - 1; i >= 0; i--) begin
			if (!flt_v_ff[i]) begin
				flt_free_ok = 1'b1;
				flt_free_idx = FIDX_W'(i);
			end
		end
	end

	matbl_key_if key ();
	assign key.vlan = cmd_vlan_in;
	assign key.addr = cmd_addr_in;

	matbl_next u_next (
		.tbl_in      (tbl_ff),
		.dyn_only_in (cmd_dyn_only_in),
		.key         (key)
	);

	logic [IDX_W:0]  cmd_hit;
	logic [IDX_W:0]  src_hit;
	logic [IDX_W:0]  dst_hit;
	logic [FIDX_W:0] flt_hit_s;
	logic [FIDX_W:0] flt_hit_d;
	logic [FIDX_W:0] flt_hit_c;
	logic            mgmt_busy;
	assign cmd_hit   = find_slot(cmd_addr_in, cmd_vlan_in, tbl_ff);
	assign src_hit   = find_slot(source_station_address_in, frm_vlan_in, tbl_ff);
	assign dst_hit   = find_slot(destination_station_address_in, frm_vlan_in, tbl_ff);
	assign flt_hit_s = find_flt(source_station_address_in, frm_vlan_in, flt_v_ff, flt_a_ff,
		flt_vl_ff);
	assign flt_hit_d = find_flt(destination_station_address_in, frm_vlan_in, flt_v_ff,
		flt_a_ff, flt_vl_ff);
	assign flt_hit_c = find_flt(cmd_addr_in, cmd_vlan_in, flt_v_ff, flt_a_ff, flt_vl_ff);
	// Any command other than read or set-age wins the table in a shared cycle; that frame does not learn
	assign mgmt_busy = cmd_valid_in && cmd_op != MATBL_CMD_READ_FROM
		&& cmd_op != MATBL_CMD_SET_AGE;

	// ------------------------------------------------------------
	// Aging time and second tick
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in || sec_tick) begin
			tick_cnt_ff <= '0;
		end else begin
			tick_cnt_ff <= tick_cnt_ff + 1'b1;
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			age_time_ff <= AGE_DEF_S;
		end else if (cmd_valid_in && cmd_op == MATBL_CMD_SET_AGE &&
			cmd_age_in >= AGE_MIN_S && cmd_age_in <= AGE_MAX_S) begin
			age_time_ff <= cmd_age_in;
		end
	end

	// ------------------------------------------------------------
	// Forwarding table update
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			for (int i = 0; i < DEPTH; i++) begin
				tbl_ff[i] <= '0;
			end
		end else begin
			for (int i = 0; i < DEPTH; i++) begin
				if (sec_tick && tbl_ff[i].valid && !tbl_ff[i].fixed) begin
					if (tbl_ff[i].age + 1'b1 >= age_time_ff) begin
						tbl_ff[i].valid <= 1'b0;
					end else begin
						tbl_ff[i].age <= tbl_ff[i].age + 1'b1;
					end
				end
			end
			if (cmd_valid_in) begin
				unique case (cmd_op)
					MATBL_CMD_ADD_FIXED: begin
						if (cmd_hit[IDX_W] || free_ok) begin
							tbl_ff[cmd_hit[IDX_W] ? cmd_hit[IDX_W-1:0] : free_idx] <=
								'{valid: 1'b1, fixed: 1'b1, vlan: cmd_vlan_in,
								addr: cmd_addr_in, ports: port_bit(cmd_port_in), age: '0};
						end
					end
					MATBL_CMD_DEL_FIXED: begin
						if (cmd_hit[IDX_W] && tbl_ff[cmd_hit[IDX_W-1:0]].fixed) begin
							tbl_ff[cmd_hit[IDX_W-1:0]].valid <= 1'b0;
						end
					end
					MATBL_CMD_CONVERT: begin
						if (cmd_hit[IDX_W]) begin
							tbl_ff[cmd_hit[IDX_W-1:0]].fixed <= 1'b1;
						end
					end
					MATBL_CMD_FLUSH: begin
						for (int i = 0; i < DEPTH; i++) begin
							if (!tbl_ff[i].fixed) begin
								tbl_ff[i].valid <= 1'b0;
							end
						end
					end
					default: begin
					end
				endcase
			end
			if (frm_valid_in && !mgmt_busy && !flt_hit_s[FIDX_W]) begin
				if (src_hit[IDX_W]) begin
					if (!tbl_ff[src_hit[IDX_W-1:0]].fixed) begin
						tbl_ff[src_hit[IDX_W-1:0]].ports <= port_bit(frm_port_in);
						tbl_ff[src_hit[IDX_W-1:0]].age <= '0;
						tbl_ff[src_hit[IDX_W-1:0]].valid <= 1'b1;
					end
				end else if (free_ok) begin
					tbl_ff[free_idx] <= '{valid: 1'b1, fixed: 1'b0, vlan: frm_vlan_in,
						addr: source_station_address_in, ports: port_bit(frm_port_in),
						age: '0};
				end
			end
		end
	end

	// ------------------------------------------------------------
	// Filter list
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			flt_v_ff <= '0;
			for (int i = 0; i < FDEPTH; i++) begin
				flt_a_ff[i] <= '0;
				flt_vl_ff[i] <= '0;
			end
		end else if (cmd_valid_in && cmd_op == MATBL_CMD_FLT_ADD && !flt_hit_c[FIDX_W] &&
			flt_free_ok && cmd_vlan_in >= VLAN_MIN && cmd_vlan_in <= VLAN_MAX) begin
			flt_v_ff[flt_free_idx] <= 1'b1;
			flt_a_ff[flt_free_idx] <= cmd_addr_in;
			flt_vl_ff[flt_free_idx] <= cmd_vlan_in;
		end else if (cmd_valid_in && cmd_op == MATBL_CMD_FLT_DEL && flt_hit_c[FIDX_W]) begin
			flt_v_ff[flt_hit_c[FIDX_W-1:0]] <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Frame lookup result
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			fwd_valid_out <= 1'b0;
			fwd_ports_out <= '0;
			fwd_flood_out <= 1'b0;
			fwd_drop_out <= 1'b0;
		end else begin
			fwd_valid_out <= frm_valid_in;
			fwd_drop_out <= frm_valid_in && (flt_hit_s[FIDX_W] || flt_hit_d[FIDX_W]);
			fwd_ports_out <= dst_hit[IDX_W] ? tbl_ff[dst_hit[IDX_W-1:0]].ports : '0;
			fwd_flood_out <= frm_valid_in && !dst_hit[IDX_W];
		end
	end

	// ------------------------------------------------------------
	// Management answer
	// ------------------------------------------------------------
	logic cmd_ok;
	always_comb begin
		unique case (cmd_op)
			MATBL_CMD_ADD_FIXED: cmd_ok = cmd_hit[IDX_W] || free_ok;
			MATBL_CMD_DEL_FIXED: cmd_ok = cmd_hit[IDX_W] && tbl_ff[cmd_hit[IDX_W-1:0]].fixed;
			MATBL_CMD_CONVERT:   cmd_ok = cmd_hit[IDX_W];
			MATBL_CMD_FLUSH:     cmd_ok = 1'b1;
			MATBL_CMD_FLT_ADD:   cmd_ok = (flt_hit_c[FIDX_W] || flt_free_ok) &&
				cmd_vlan_in >= VLAN_MIN && cmd_vlan_in <= VLAN_MAX;
			MATBL_CMD_FLT_DEL:   cmd_ok = flt_hit_c[FIDX_W];
			MATBL_CMD_SET_AGE:   cmd_ok = cmd_age_in >= AGE_MIN_S && cmd_age_in <= AGE_MAX_S;
			MATBL_CMD_READ_FROM: cmd_ok = 1'b1;
		endcase
	end

	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			cmd_done_out <= 1'b0;
			cmd_err_out <= 1'b0;
			age_time_out <= AGE_DEF_S;
		end else begin
			cmd_done_out <= cmd_valid_in;
			cmd_err_out <= cmd_valid_in && !cmd_ok;
			age_time_out <= age_time_ff;
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			rd_valid_out <= 1'b0;
			rd_found_out <= 1'b0;
			rd_addr_out <= '0;
			rd_vlan_out <= '0;
			rd_ports_out <= '0;
			rd_fixed_out <= 1'b0;
		end else begin
			rd_valid_out <= cmd_valid_in && cmd_op == MATBL_CMD_READ_FROM;
			rd_found_out <= key.found;
			rd_addr_out <= tbl_ff[key.idx].addr;
			rd_vlan_out <= tbl_ff[key.idx].vlan;
			rd_ports_out <= tbl_ff[key.idx].ports;
			rd_fixed_out <= tbl_ff[key.idx].fixed;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	// Any learned entry still in the table, whatever its slot
	logic learned_left;
	always_comb begin
		learned_left = 1'b0;
		for (int i = 0; i < DEPTH; i++) begin
			learned_left = learned_left | (tbl_ff[i].valid & ~tbl_ff[i].fixed);
		end
	end

	a_age_reset: assert property (@(posedge sys_clk_in) $fell(sys_rst_in) |->
		age_time_out == AGE_DEF_S) else $error("aging time not default");
	a_age_range: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
		age_time_ff >= AGE_MIN_S && age_time_ff <= AGE_MAX_S)
		else $error("aging time out of range");
	a_flush_keep: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
		cmd_valid_in && cmd_op == MATBL_CMD_FLUSH && !frm_valid_in |=>
		!learned_left) else $error("learned entry survived");
	a_fixed_noage: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
		tbl_ff[0].valid && tbl_ff[0].fixed && !cmd_valid_in |=> tbl_ff[0].valid)
		else $error("fixed entry vanished");
	a_fwd_hit: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
		frm_valid_in && dst_hit[IDX_W] |=> fwd_valid_out && !fwd_flood_out && fwd_ports_out != '0)
		else $error("hit not forwarded");
	a_filter_drop: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
		frm_valid_in && flt_hit_d[FIDX_W] |=> fwd_drop_out) else $error("no drop");
	a_learn_src: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
		frm_valid_in && !mgmt_busy && !flt_hit_s[FIDX_W] && free_ok && !sec_tick |=>
		find_slot($past(source_station_address_in), $past(frm_vlan_in), tbl_ff) != '0)
		else $error("source not learned");
	a_del_fixed: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
		cmd_valid_in && cmd_op == MATBL_CMD_DEL_FIXED && cmd_ok && !frm_valid_in |=>
		find_slot($past(cmd_addr_in), $past(cmd_vlan_in), tbl_ff) == '0)
		else $error("fixed entry kept");
	c_read: cover property (@(posedge sys_clk_in) rd_valid_out && rd_found_out);
	c_flush: cover property (@(posedge sys_clk_in) cmd_valid_in && cmd_op == MATBL_CMD_FLUSH);
	c_drop: cover property (@(posedge sys_clk_in) fwd_drop_out);
endmodule
`default_nettype wire

// ==== test/matbl_top_tb.sv ====
// Testbench: self-checking scenarios for the station address forwarding table
`timescale 1ns/1ps
`default_nettype none
module matbl_top_tb;
	import matbl_pkg::*;
	logic              sys_clk_in;
	logic              sys_rst_in;
	logic              frm_valid_in;
	logic [ADDR_W-1:0] dst_in;
	logic [ADDR_W-1:0] src_in;
	logic [VLAN_W-1:0] frm_vlan_in;
	logic [PORT_W-1:0] frm_port_in;
	logic              fwd_valid_out;
	logic [NPORTS:0]   fwd_ports_out;
	logic              fwd_flood_out;
	logic              fwd_drop_out;
	logic              cmd_valid_in;
	logic [2:0]        cmd_op_in;
	logic [ADDR_W-1:0] cmd_addr_in;
	logic [VLAN_W-1:0] cmd_vlan_in;
	logic [PORT_W-1:0] cmd_port_in;
	logic [AGE_W-1:0]  cmd_age_in;
	logic              cmd_dyn_only_in;
	logic              cmd_done_out;
	logic              cmd_err_out;
	logic              rd_valid_out;
	logic              rd_found_out;
	logic [ADDR_W-1:0] rd_addr_out;
	logic [VLAN_W-1:0] rd_vlan_out;
	logic [NPORTS:0]   rd_ports_out;
	logic              rd_fixed_out;
	logic [AGE_W-1:0]  age_time_out;
	int                failures;
	int                tests_run;
	localparam logic [ADDR_W-1:0] ADR_A = 48'h00000A0A0001;
	localparam logic [ADDR_W-1:0] ADR_B = 48'h000000B00001;
	localparam logic [ADDR_W-1:0] ADR_C = 48'h000000000C01;
	localparam logic [ADDR_W-1:0] ADR_D = 48'h0000000D0001;
	matbl_top u_dut (
		.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .frm_valid_in(frm_valid_in),
		.destination_station_address_in(dst_in), .source_station_address_in(src_in),
		.frm_vlan_in(frm_vlan_in), .frm_port_in(frm_port_in), .fwd_valid_out(fwd_valid_out),
		.fwd_ports_out(fwd_ports_out), .fwd_flood_out(fwd_flood_out),
		.fwd_drop_out(fwd_drop_out), .cmd_valid_in(cmd_valid_in), .cmd_op_in(cmd_op_in),
		.cmd_addr_in(cmd_addr_in), .cmd_vlan_in(cmd_vlan_in), .cmd_port_in(cmd_port_in),
		.cmd_age_in(cmd_age_in), .cmd_dyn_only_in(cmd_dyn_only_in),
		.cmd_done_out(cmd_done_out), .cmd_err_out(cmd_err_out), .rd_valid_out(rd_valid_out),
		.rd_found_out(rd_found_out), .rd_addr_out(rd_addr_out), .rd_vlan_out(rd_vlan_out),
		.rd_ports_out(rd_ports_out), .rd_fixed_out(rd_fixed_out),
		.age_time_out(age_time_out)
	);
	// ----------------------------------------
	// Clock, compare and bus tasks
	// ----------------------------------------
	initial begin
		sys_clk_in = 1'b0;
		forever #12.5 sys_clk_in = ~sys_clk_in;
	end
	task automatic chk_bit(input logic got, input logic exp, input string what);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("Error at %0t: %s got %b want %b", $time, what, got, exp);
		end
	endtask
	task automatic chk_val(input logic [63:0] got, input logic [63:0] exp, input string what);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("Error at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask
	task automatic frame(input logic [ADDR_W-1:0] s, input logic [ADDR_W-1:0] d,
		input logic [VLAN_W-1:0] v, input logic [PORT_W-1:0] p);
		@(posedge sys_clk_in);
		frm_valid_in <= 1'b1;
		src_in       <= s;
		dst_in       <= d;
		frm_vlan_in  <= v;
		frm_port_in  <= p;
		@(posedge sys_clk_in);
		frm_valid_in <= 1'b0;
		#1;
		chk_bit(fwd_valid_out, 1'b1, "fwd valid");
	endtask
	task automatic cmd(input matbl_cmd_t op, input logic [ADDR_W-1:0] a,
		input logic [VLAN_W-1:0] v, input logic [PORT_W-1:0] p,
		input logic [AGE_W-1:0] age, input logic dyn, input logic exp_err);
		@(posedge sys_clk_in);
		cmd_valid_in    <= 1'b1;
		cmd_op_in       <= op;
		cmd_addr_in     <= a;
		cmd_vlan_in     <= v;
		cmd_port_in     <= p;
		cmd_age_in      <= age;
		cmd_dyn_only_in <= dyn;
		@(posedge sys_clk_in);
		cmd_valid_in <= 1'b0;
		#1;
		chk_bit(cmd_done_out, 1'b1, "cmd done");
		chk_bit(rd_valid_out, op == MATBL_CMD_READ_FROM, "rd valid");
		chk_bit(cmd_err_out, exp_err, "cmd err");
	endtask
	task automatic rd_chk(input logic [VLAN_W-1:0] v, input logic [ADDR_W-1:0] a,
		input logic fx, input logic [NPORTS:0] pt);
		chk_bit(rd_found_out, 1'b1, "rd found");
		chk_val(64'(rd_vlan_out), 64'(v), "rd vlan");
		chk_val(64'(rd_addr_out), 64'(a), "rd addr");
		chk_bit(rd_fixed_out, fx, "rd type");
		chk_val(64'(rd_ports_out), 64'(pt), "rd ports");
	endtask
	task automatic fwd_chk(input logic [NPORTS:0] pt, input logic fl);
		chk_val(64'(fwd_ports_out), 64'(pt), "fwd ports");
		chk_bit(fwd_flood_out, fl, "fwd flood");
	endtask
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_learn_fixed();
		frame(ADR_A, ADR_D, 12'h005, 5'h03);
		fwd_chk(19'h00000, 1'b1); // unknown destination floods
		frame(ADR_C, ADR_A, 12'h005, 5'h07);
		fwd_chk(19'h00008, 1'b0); // learned ingress port
		cmd(MATBL_CMD_ADD_FIXED, ADR_B, 12'h001, CPU_PORT, 10'h000, 1'b0, 1'b0);
		// Source equals the fixed entry: learning must leave it alone
		frame(ADR_B, ADR_B, 12'h001, 5'h01);
		fwd_chk(19'h40000, 1'b0); // forwards to processor port
		$display("test learn_fixed done");
	endtask
	task automatic t_read_order();
		cmd(MATBL_CMD_READ_FROM, 48'h0, 12'h000, 5'h00, 10'h000, 1'b0, 1'b0);
		rd_chk(12'h001, ADR_B, 1'b1, 19'h40000); // lowest vlan first
		cmd(MATBL_CMD_READ_FROM, ADR_B + 48'h1, 12'h001, 5'h00, 10'h000, 1'b0, 1'b0);
		rd_chk(12'h005, ADR_C, 1'b0, 19'h00080); // then lower address
		cmd(MATBL_CMD_READ_FROM, ADR_C + 48'h1, 12'h005, 5'h00, 10'h000, 1'b0, 1'b0);
		rd_chk(12'h005, ADR_A, 1'b0, 19'h00008); // starts at given key
		cmd(MATBL_CMD_READ_FROM, 48'h0, 12'h000, 5'h00, 10'h000, 1'b1, 1'b0);
		rd_chk(12'h005, ADR_C, 1'b0, 19'h00080); // learned only skips fixed
		cmd(MATBL_CMD_READ_FROM, ADR_A + 48'h1, 12'h005, 5'h00, 10'h000, 1'b0, 1'b0);
		chk_bit(rd_found_out, 1'b0, "rd past end"); // nothing after last
		$display("test read_order done");
	endtask
	task automatic t_convert();
		cmd(MATBL_CMD_CONVERT, ADR_A, 12'h005, 5'h00, 10'h000, 1'b0, 1'b0);
		cmd(MATBL_CMD_CONVERT, ADR_A, 12'h009, 5'h00, 10'h000, 1'b0, 1'b1); // miss
		cmd(MATBL_CMD_READ_FROM, ADR_A, 12'h005, 5'h00, 10'h000, 1'b0, 1'b0);
		rd_chk(12'h005, ADR_A, 1'b1, 19'h00008); // now reported fixed
		$display("test convert done");
	endtask
	task automatic t_age();
		logic [AGE_W-1:0] vals [5];
		logic             errs [5];
		logic [AGE_W-1:0] want;
		vals = '{10'h009, 10'h277, 10'h00A, 10'h276, 10'h12C};
		errs = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
		want = AGE_DEF_S;
		for (int i = 0; i < 5; i++) begin
			cmd(MATBL_CMD_SET_AGE, 48'h0, 12'h000, 5'h00, vals[i], 1'b0, errs[i]);
			if (!errs[i]) begin
				want = vals[i];
			end
			@(posedge sys_clk_in);
			#1;
			chk_val(64'(age_time_out), 64'(want), "age time"); // range kept
		end
		$display("test age done");
	endtask
	task automatic t_filter();
		cmd(MATBL_CMD_FLT_ADD, ADR_D, 12'h000, 5'h00, 10'h000, 1'b0, 1'b1); // vlan 0
		cmd(MATBL_CMD_FLT_ADD, ADR_D, 12'hFFF, 5'h00, 10'h000, 1'b0, 1'b1); // vlan 4095
		cmd(MATBL_CMD_FLT_ADD, ADR_D, VLAN_MAX, 5'h00, 10'h000, 1'b0, 1'b0);
		frame(ADR_B, ADR_D, VLAN_MAX, 5'h02);
		chk_bit(fwd_drop_out, 1'b1, "drop listed"); // listed pair dropped
		frame(ADR_B, ADR_D, 12'h001, 5'h02);
		chk_bit(fwd_drop_out, 1'b0, "other vlan"); // pair needs both
		$display("test filter done");
	endtask
	task automatic t_flush_del();
		cmd(MATBL_CMD_FLUSH, 48'h0, 12'h000, 5'h00, 10'h000, 1'b0, 1'b0);
		frame(ADR_D, ADR_C, 12'h005, 5'h01);
		fwd_chk(19'h00000, 1'b1); // learned entry gone
		frame(ADR_D, ADR_A, 12'h005, 5'h01);
		fwd_chk(19'h00008, 1'b0); // fixed entry kept
		frame(ADR_C, ADR_D, VLAN_MAX, 5'h01);
		chk_bit(fwd_drop_out, 1'b1, "filter kept"); // filter kept
		cmd(MATBL_CMD_DEL_FIXED, ADR_B, 12'h001, 5'h00, 10'h000, 1'b0, 1'b0);
		frame(ADR_D, ADR_B, 12'h001, 5'h01);
		fwd_chk(19'h00000, 1'b1); // deleted entry misses
		cmd(MATBL_CMD_DEL_FIXED, ADR_B, 12'h001, 5'h00, 10'h000, 1'b0, 1'b1); // absent
		cmd(MATBL_CMD_FLT_DEL, ADR_D, VLAN_MAX, 5'h00, 10'h000, 1'b0, 1'b0);
		frame(ADR_C, ADR_D, VLAN_MAX, 5'h01);
		chk_bit(fwd_drop_out, 1'b0, "filter removed"); // unlisted passes
		$display("test flush_del done");
	endtask
	// ----------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------
	initial begin
		failures = 0;
		tests_run = 0;
		sys_rst_in = 1'b1;
		{frm_valid_in, dst_in, src_in, frm_vlan_in, frm_port_in} = '0;
		{cmd_valid_in, cmd_op_in, cmd_addr_in, cmd_vlan_in} = '0;
		{cmd_port_in, cmd_age_in, cmd_dyn_only_in} = '0;
		repeat (12) @(posedge sys_clk_in);
		sys_rst_in <= 1'b0;
		#1;
		chk_val(64'(age_time_out), 64'(AGE_DEF_S), "age default"); // default 300
		chk_bit(fwd_valid_out, 1'b0, "idle fwd");
		chk_bit(cmd_done_out, 1'b0, "idle done");
		t_learn_fixed();
		t_read_order();
		t_convert();
		t_age();
		t_filter();
		t_flush_del();
		summarize();
	end
	// Far above the fewer than a hundred cycles the scenarios need
	initial begin
		repeat (20000) @(posedge sys_clk_in);
		failures++;
		$display("Error at %0t: watchdog expired", $time);
		summarize();
	end
endmodule
`default_nettype wire
